// [bdic_checker.sv]
// Concurrent checks on the pin and bus ports of the bridge driver input control.
// Assumes input filters settle within four cycles and aresetn is synchronous, active low.
`timescale 1ns/1ps
module bdic_checker
  import bdic_pkg::*;
(
  // Clock and reset.
  input logic                 aclk,
  input logic                 aresetn,
  // Observed ports.
  input bdic_pkg::bdic_pin_s  pins,
  input bdic_pkg::bdic_gate_s gates,
  input logic [2:0]           phase_feedback,
  input logic [2:0]           phase_feedback_oe,
  input logic                 serial_out_oe,
  input logic                 supply_en,
  input logic                 s_axi_arvalid,
  input logic                 s_axi_arready,
  input logic                 s_axi_rvalid
);
  // One clock domain, so one default clocking and one reset disable serve every check.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Held levels are required, except in AST_NO_SHOOT and AST_BUS_SAFE_OFF_N, so that the input filter latency never trips a check.
  AST_NO_SHOOT: assert property (!(|(gates.hs_gate & gates.ls_gate)))
    else $error("both gates of one half-bridge on");
  AST_SAFE_OFF: assert property ((!pins.safe_off_n) [*5] |-> gates == '0)
    else $error("gate on during safe-off");
  AST_ENA_LOW: assert property ((!pins.stage_enable_clear) [*6] |-> gates == '0)
    else $error("gate on while enable low");
  AST_SLEEP_GATE: assert property ((!pins.sleep_request_n) [*7] |-> gates == '0)
    else $error("gate on during power-down");
  AST_SLEEP_SUP: assert property ((!pins.sleep_request_n && pins.bootstrap_uv) [*8]
    |-> ##[0:4] !supply_en) else $error("supplies kept on after bootstrap undervoltage");
  AST_FEEDBACK: assert property ($stable(pins.phase_node_cmp) [*7]
    |-> phase_feedback == pins.phase_node_cmp) else $error("feedback differs from node");
  AST_PAD_SHORT: assert property (pins.pad_short[0] [*6] |-> ##[0:3] !phase_feedback_oe[0])
    else $error("shorted pad still driven");
  AST_BUS_SAFE_OFF_N: assert property (!pins.safe_off_n && s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered in safe-off");
  AST_SDO_OFF: assert property ((!supply_en) [*3] |-> !serial_out_oe)
    else $error("serial output driven without supply");
  // Main scenarios.
  cover property ((!pins.safe_off_n) [*5] ##1 s_axi_rvalid);
  cover property ($fell(pins.stage_enable_clear));
  cover property (gates.ls_gate[0] ##1 !gates.ls_gate[0]);
endmodule // bdic_checker

bind bdic_core bdic_checker u_bdic_checker (.aclk(aclk), .aresetn(aresetn), .pins(pins),
  .gates(gates), .phase_feedback(phase_feedback), .phase_feedback_oe(phase_feedback_oe),
  .serial_out_oe(serial_out_oe), .supply_en(supply_en), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// [bdic_core.sv]
// Input control of a three-phase gate driver: pin gating, dead time, power states,
// safe-off, supply monitor settings, output pad protection and an AXI4-Lite register file.
// Assumes all pin inputs are asynchronous and all bus signals are on aclk.
`timescale 1ns/1ps
`include "bdic_map.svh"
module bdic_core #(
  parameter int NPH = 3 // Number of half-bridges.
) (
  // Clock and reset.
  input  logic                aclk,
  input  logic                aresetn,
  // Pins from the controller and analog comparators.
  input  bdic_pkg::bdic_pin_s pins,
  // Gate drive.
  output bdic_pkg::bdic_gate_s gates,
  // Digital outputs with enables.
  output logic [2:0]          phase_feedback,
  output logic [2:0]          phase_feedback_oe,
  output logic                fault_n,
  output logic                fault_n_oe,
  output logic                serial_out_oe,
  output logic                supply_en,
  // AXI4-Lite write address.
  input  logic                s_axi_awvalid,
  output logic                s_axi_awready,
  input  logic [3:0]          s_axi_awaddr,
  // AXI4-Lite write data.
  input  logic                s_axi_wvalid,
  output logic                s_axi_wready,
  input  logic [31:0]         s_axi_wdata,
  input  logic [3:0]          s_axi_wstrb,
  // AXI4-Lite write response.
  output logic                s_axi_bvalid,
  input  logic                s_axi_bready,
  output logic [1:0]          s_axi_bresp,
  // AXI4-Lite read address.
  input  logic                s_axi_arvalid,
  output logic                s_axi_arready,
  input  logic [3:0]          s_axi_araddr,
  // AXI4-Lite read data.
  output logic                s_axi_rvalid,
  input  logic                s_axi_rready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp
);
  import bdic_pkg::*;

  localparam int PW = $bits(bdic_pin_s);

  // Three-stage pin synchronisers and the filtered pin state.
  logic [PW-1:0] ff1_r, ff2_r, ff3_r, pin_r;
  bdic_pin_s     pin;
  assign pin = bdic_pin_s'(pin_r);

  // A pin change counts only once stages two and three agree; stage one feeds stage two alone.
  // The reset value leaves every drive input at its FET-off level.
  // Held as a full-width constant so that each stage takes exactly its own bit.
  localparam logic [PW-1:0] PIN_RST = `BDIC_PIN_RST;
  genvar gb;
  generate
    for (gb = 0; gb < PW; gb++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ff1_r[gb] <= PIN_RST[gb];
          ff2_r[gb] <= PIN_RST[gb];
          ff3_r[gb] <= PIN_RST[gb];
          pin_r[gb] <= PIN_RST[gb];
        end else begin
          ff1_r[gb] <= pins[gb];
          ff2_r[gb] <= ff1_r[gb];
          ff3_r[gb] <= ff2_r[gb];
          if (ff2_r[gb] == ff3_r[gb]) begin
            pin_r[gb] <= ff3_r[gb];
          end
        end
      end
    end
  endgenerate

  // Power state machine.
  bdic_state_e state_r, state_nxt;
  logic        active;
  assign active = (state_r == ST_ACTIVE);

  // Power-down runs until the bootstrap node collapses; waking restarts from defaults.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_SLEEP:  if (pin.sleep_request_n) state_nxt = ST_ACTIVE;
      ST_ACTIVE: if (!pin.sleep_request_n) state_nxt = ST_PWRDN;
      ST_PWRDN:  if (pin.bootstrap_uv) state_nxt = ST_SLEEP;
      default:   state_nxt = ST_SLEEP;
    endcase
  end

  // Supplies stay up through power-down so the gates can be pulled off actively.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r   <= ST_SLEEP;
      supply_en <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      supply_en <= (state_nxt != ST_SLEEP);
    end
  end

  // Enable falling edge detection on the filtered pin.
  logic ena_d_r;
  logic ena_fall;
  assign ena_fall = ena_d_r & ~pin.stage_enable_clear;
  always_ff @(posedge aclk) begin
    if (!aresetn) ena_d_r <= 1'b0;
    else          ena_d_r <= pin.stage_enable_clear;
  end

  // Configuration registers.
  logic [3:0] ctrl_r, ctrl_nxt;
  logic [7:0] deadt_r, deadt_nxt;
  logic       cfg_mode, vcc_3v3, mon_dis, sdo_off;
  assign cfg_mode = ctrl_r[`BDIC_CTRL_CFG];
  assign vcc_3v3  = ctrl_r[`BDIC_CTRL_V33];
  assign mon_dis  = ctrl_r[`BDIC_CTRL_MONDIS];
  assign sdo_off  = ctrl_r[`BDIC_CTRL_SDOOFF];

  // Supply monitor events; vcc_3v3 is only stored, and no output carries it to the comparators.
  logic mon_uv, mon_ov;
  assign mon_uv = pin.vcc_uv & ~mon_dis & active;
  assign mon_ov = pin.vcc_ov & ~mon_dis & active;

  // Pad disconnect state, held until an enable falling edge.
  logic [4:0] disc_r;
  logic [4:0] short_ev;
  assign short_ev = pin.pad_short & {5{supply_en}};
  always_ff @(posedge aclk) begin
    if (!aresetn) disc_r <= 5'h00;
    else          disc_r <= (disc_r & ~{5{ena_fall}}) | short_ev;
  end

  // Latched error: any fault stops the stages until enable falls; a new fault wins.
  logic latched_r;
  logic fault_ev;
  assign fault_ev = mon_uv | mon_ov | (pin.bootstrap_uv & active) | (|short_ev);
  always_ff @(posedge aclk) begin
    if (!aresetn) latched_r <= 1'b0;
    else          latched_r <= (latched_r & ~ena_fall) | fault_ev;
  end

  // Error register: sticky, cleared by readout only, the enable pin has no effect.
  logic [7:0] err_r, err_set;
  logic [7:0] err_clr;
  assign err_set = {short_ev, pin.bootstrap_uv & active, mon_ov, mon_uv};
  always_ff @(posedge aclk) begin
    if (!aresetn) err_r <= 8'h00;
    else          err_r <= (err_r & ~err_clr) | err_set;
  end

  // Stage enable from the main logic path.
  logic main_en;
  assign main_en = active & pin.stage_enable_clear & ~latched_r;

  // Per-phase dead time and cross-conduction lockout; no minimum pulse so 0 to 100 % works.
  logic [NPH-1:0] hs_on_r, ls_on_r;
  genvar gp;
  generate
    for (gp = 0; gp < NPH; gp++) begin : g_phase
      logic [7:0] dt_r;
      logic       want_hs, want_ls, hs_nxt, ls_nxt;
      // Both requested means neither, so a bad input pair never shorts the bridge.
      assign want_hs = ~pin.high_side_drive_n[gp] & ~pin.low_side_drive[gp] & main_en;
      assign want_ls = pin.low_side_drive[gp] & pin.high_side_drive_n[gp] & main_en;
      assign hs_nxt  = want_hs & ~ls_on_r[gp] & (dt_r == 8'h00 | hs_on_r[gp]);
      assign ls_nxt  = want_ls & ~hs_on_r[gp] & (dt_r == 8'h00 | ls_on_r[gp]);
      // Counter reloads on every turn-off and runs down before the other side may turn on.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          hs_on_r[gp] <= 1'b0;
          ls_on_r[gp] <= 1'b0;
          dt_r        <= 8'h00;
        end else begin
          hs_on_r[gp] <= hs_nxt;
          ls_on_r[gp] <= ls_nxt;
          if ((hs_on_r[gp] & ~hs_nxt) | (ls_on_r[gp] & ~ls_nxt)) begin
            dt_r <= deadt_r;
          end else if (dt_r != 8'h00) begin
            dt_r <= dt_r - 8'h01;
          end
        end
      end
    end
  endgenerate

  // The safe-off term is applied after the main flip-flops, from its own filtered pin only,
  // so a stuck main path or enable path cannot keep a gate on.
  assign gates.hs_gate = hs_on_r & {NPH{pin.safe_off_n}};
  assign gates.ls_gate = ls_on_r & {NPH{pin.safe_off_n}};

  // Digital outputs: feedback mirrors the phase comparators; shorted pads are released.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_feedback    <= 3'h0;
      phase_feedback_oe <= 3'h0;
      fault_n           <= 1'b0;
      fault_n_oe        <= 1'b0;
      serial_out_oe     <= 1'b0;
    end else begin
      phase_feedback    <= pin.phase_node_cmp;
      phase_feedback_oe <= {3{supply_en}} & ~disc_r[2:0];
      fault_n           <= ~(latched_r | (|err_r));
      fault_n_oe        <= supply_en & ~disc_r[`BDIC_PAD_FAULT];
      serial_out_oe     <= supply_en & ~sdo_off & ~disc_r[`BDIC_PAD_SDO];
    end
  end

  // AXI4-Lite write channel: address and data taken in either order, one write at a time.
  logic        aw_have_r, w_have_r;
  logic [3:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_go, wr_ok;
  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
  assign wr_go = aw_have_r & w_have_r;
  assign wr_ok = (aw_addr_r == `BDIC_CTRL_OFF) | (aw_addr_r == `BDIC_DEADT_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      aw_addr_r    <= 4'h0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BDIC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr & 4'hC;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `BDIC_RESP_OKAY : `BDIC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration write decode; monitor class and disable change only in configuration mode.
  always_comb begin
    ctrl_nxt  = ctrl_r;
    deadt_nxt = deadt_r;
    if (wr_go & w_strb_r[0] & (aw_addr_r == `BDIC_CTRL_OFF)) begin
      ctrl_nxt[`BDIC_CTRL_CFG]    = w_data_r[`BDIC_CTRL_CFG];
      ctrl_nxt[`BDIC_CTRL_SDOOFF] = w_data_r[`BDIC_CTRL_SDOOFF];
      if (cfg_mode) begin
        ctrl_nxt[`BDIC_CTRL_V33]    = w_data_r[`BDIC_CTRL_V33];
        ctrl_nxt[`BDIC_CTRL_MONDIS] = w_data_r[`BDIC_CTRL_MONDIS];
      end
    end
    if (wr_go & w_strb_r[0] & (aw_addr_r == `BDIC_DEADT_OFF)) begin
      deadt_nxt = w_data_r[7:0];
    end
  end

  // Sleep throws the configuration away so the controller must set it up again.
  always_ff @(posedge aclk) begin
    if (!aresetn || state_r == ST_SLEEP) begin
      ctrl_r  <= `BDIC_CTRL_RST;
      deadt_r <= `BDIC_DEADT_RST;
    end else begin
      ctrl_r  <= ctrl_nxt;
      deadt_r <= deadt_nxt;
    end
  end

  // AXI4-Lite read channel: stays alive in safe-off, one read at a time.
  logic        rd_go;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [3:0]  rd_addr;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go   = s_axi_arvalid & s_axi_arready;
  assign rd_addr = s_axi_araddr & 4'hC;
  assign rd_ok   = 1'b1;
  assign err_clr = (rd_go & (rd_addr == `BDIC_ERR_OFF)) ? err_r : 8'h00;

  // Read mux; the error word is the value cleared in the same cycle.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_addr)
      `BDIC_CTRL_OFF:   rd_word = {28'h0, ctrl_r};
      `BDIC_DEADT_OFF:  rd_word = {24'h0, deadt_r};
      `BDIC_STATUS_OFF: rd_word = {24'h0, state_r, pin.phase_node_cmp, pin.stage_enable_clear,
                                   ~pin.safe_off_n, latched_r};
      `BDIC_ERR_OFF:    rd_word = {24'h0, err_r};
      default:          rd_word = 32'h0000_0000;
    endcase
  end

  // Read data is registered; all four aligned words are mapped.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `BDIC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? `BDIC_RESP_OKAY : `BDIC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // bdic_core

// [bdic_core_bench.sv]
// Self-checking bench: AXI4-Lite register access plus pin scenarios.
// Assumes bdic_checker is bound to bdic_core and bdic_mcu models the controller pins.
`timescale 1ns/1ps
`include "bdic_map.svh"
module bdic_core_bench;
  import bdic_pkg::*;
  logic aclk = 0, aresetn = 0, flt = 0;
  bdic_pin_s c = '{high_side_drive_n: 3'h7, sleep_request_n: 1'b1, safe_off_n: 1'b1, default: '0};
  bdic_pin_s pins;
  bdic_gate_s gates;
  logic [2:0] phase_feedback, phase_feedback_oe, pfb_wire;
  logic fault_n, fault_n_oe, fault_wire, serial_out_oe, supply_en;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, rr;
  int n_mismatch = 0, total_checks = 0;
  // 100 MHz clock.
  always #5 aclk = ~aclk;
  bdic_core u_bdic_core (.aclk(aclk), .aresetn(aresetn), .pins(pins), .gates(gates),
    .phase_feedback(phase_feedback), .phase_feedback_oe(phase_feedback_oe), .fault_n(fault_n),
    .fault_n_oe(fault_n_oe), .serial_out_oe(serial_out_oe), .supply_en(supply_en),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
  bdic_mcu u_bdic_mcu (.cmd(c), .flt(flt), .pins(pins), .phase_feedback(phase_feedback),
    .phase_feedback_oe(phase_feedback_oe), .fault_n(fault_n), .fault_n_oe(fault_n_oe),
    .pfb_wire(pfb_wire), .fault_wire(fault_wire));
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Value compare; four-state so an unknown never matches.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write: address and data offered together, each released when taken.
  // Waits have no limit of their own; only the watchdog ends a hung transfer.
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_awvalid <= 1; s_axi_awaddr <= a; s_axi_wvalid <= 1;
    s_axi_wdata <= v; s_axi_wstrb <= 4'hF; s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  // Read: address held until taken, rready held until data is seen.
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge aclk);
    s_axi_arvalid <= 1; s_axi_araddr <= a; s_axi_rready <= 1;
    @(posedge aclk);
    while (s_axi_arready !== 1'b1) @(posedge aclk);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog sized well above the roughly 340 cycles of the sequence.
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    cyc(5); aresetn <= 1; cyc(12);
    rd(`BDIC_CTRL_OFF, d); chk("ctrl reset", 32'h1, d);
    rd(`BDIC_DEADT_OFF, d); chk("deadt reset", 32'h10, d);
    wr(`BDIC_STATUS_OFF, 32'h0, r); chk("ro write resp", `BDIC_RESP_SLVERR, r);
    wr(`BDIC_CTRL_OFF, 32'h7, r); rd(`BDIC_CTRL_OFF, d); chk("cfg ctrl", 32'h7, d);
    c.vcc_uv <= 1; cyc(8); c.vcc_uv <= 0; cyc(8);
    rd(`BDIC_ERR_OFF, d); chk("monitor off err", 32'h0, d);
    wr(`BDIC_CTRL_OFF, 32'h0, r); wr(`BDIC_CTRL_OFF, 32'h6, r);
    rd(`BDIC_CTRL_OFF, d); chk("ctrl out of cfg", 32'h0, d);
    wr(`BDIC_CTRL_OFF, 32'h8, r); cyc(3); chk("sdo oe", 32'h0, serial_out_oe);
    wr(`BDIC_CTRL_OFF, 32'h0, r);
    c.stage_enable_clear <= 1; c.high_side_drive_n <= 3'h6; cyc(10);
    chk("hs on", 32'h08, gates);
    c.high_side_drive_n <= 3'h7; c.low_side_drive <= 3'h1; cyc(10);
    chk("dead time", 32'h00, gates);
    cyc(20); chk("ls on", 32'h01, gates);
    c.high_side_drive_n <= 3'h6; cyc(30); chk("both req", 32'h00, gates);
    c.low_side_drive <= 3'h0; cyc(30); chk("hs again", 32'h08, gates);
    c.stage_enable_clear <= 0; cyc(10); chk("ena low", 32'h00, gates);
    c.stage_enable_clear <= 1; cyc(30); chk("ena high", 32'h08, gates);
    c.safe_off_n <= 0; cyc(8); chk("safe off", 32'h00, gates);
    c.safe_off_n <= 1; flt <= 1; cyc(10); chk("open inputs", 32'h00, gates);
    flt <= 0; c.phase_node_cmp <= 3'h5; cyc(10); chk("feedback", 32'h5, pfb_wire);
    c.pad_short[0] <= 1; c.vcc_uv <= 1; c.vcc_ov <= 1; cyc(8);
    c.pad_short[0] <= 0; c.vcc_uv <= 0; c.vcc_ov <= 0; cyc(8);
    chk("fault wire", 32'h0, fault_wire);
    chk("pad oe", 32'h0, phase_feedback_oe[0]);
    c.safe_off_n <= 0; cyc(8);
    rd(`BDIC_STATUS_OFF, d); chk("safe_off_n status", 32'h3, d & 32'h3);
    chk("safe_off_n read resp", `BDIC_RESP_OKAY, rr);
    c.safe_off_n <= 1; c.stage_enable_clear <= 0; cyc(10);
    rd(`BDIC_STATUS_OFF, d); chk("latch clear", 32'h0, d & 32'h1);
    rd(`BDIC_ERR_OFF, d); chk("err kept", 32'h0B, d);
    rd(`BDIC_ERR_OFF, d); chk("err read clear", 32'h0, d);
    c.stage_enable_clear <= 1; wr(`BDIC_DEADT_OFF, 32'h4, r);
    c.sleep_request_n <= 0; c.bootstrap_uv <= 1; cyc(20);
    chk("supply off", 32'h0, supply_en);
    chk("sleep gates", 32'h00, gates);
    c.sleep_request_n <= 1; c.bootstrap_uv <= 0; cyc(15);
    rd(`BDIC_DEADT_OFF, d); chk("config lost", 32'h10, d);
    wr(`BDIC_DEADT_OFF, 32'h4, r); rd(`BDIC_DEADT_OFF, d); chk("reconfig", 32'h4, d);
    tally_and_finish();
  end
endmodule // bdic_core_bench

// [bdic_map.svh]
// Offsets, field positions, reset values and pin layout for the bridge driver input control.
// Assumes a 32-bit AXI4-Lite bus with byte addresses and one word per register.
`ifndef BDIC_MAP_SVH
`define BDIC_MAP_SVH
// Register byte offsets.
`define BDIC_CTRL_OFF    4'h0
`define BDIC_DEADT_OFF   4'h4
`define BDIC_STATUS_OFF  4'h8
`define BDIC_ERR_OFF     4'hC
// Control register fields.
`define BDIC_CTRL_CFG    0
`define BDIC_CTRL_V33    1
`define BDIC_CTRL_MONDIS 2
`define BDIC_CTRL_SDOOFF 3
`define BDIC_CTRL_RST    4'h1
`define BDIC_DEADT_RST   8'h10
// Error register fields.
`define BDIC_ERR_VUV     0
`define BDIC_ERR_VOV     1
`define BDIC_ERR_BUV     2
`define BDIC_ERR_SHORT   3
// Pad indices of the shorted-output inputs.
`define BDIC_PAD_FAULT   3
`define BDIC_PAD_SDO     4
// Pin vector reset value: high-side inputs idle high, all else low.
`define BDIC_PIN_RST     20'hE0000
// AXI responses.
`define BDIC_RESP_OKAY   2'h0
`define BDIC_RESP_SLVERR 2'h2
`endif

// [bdic_mcu.sv]
// Controller side of the pins: drives the inputs and resolves the outputs on the wires.
// Assumes the bench gives requested levels; a released output falls to its pull-down.
`timescale 1ns/1ps
module bdic_mcu
  import bdic_pkg::*;
(
  // Requested levels, and a flag that leaves the drive inputs unconnected.
  input  bdic_pkg::bdic_pin_s cmd,
  input  logic                flt,
  // Pins toward the device.
  output bdic_pkg::bdic_pin_s pins,
  // Device outputs and the wire levels seen by the controller.
  input  logic [2:0]          phase_feedback,
  input  logic [2:0]          phase_feedback_oe,
  input  logic                fault_n,
  input  logic                fault_n_oe,
  output logic [2:0]          pfb_wire,
  output logic                fault_wire
);
  // Open drive inputs take their pull levels, which must mean FET off.
  always_comb begin
    pins = cmd;
    if (flt) begin
      pins.high_side_drive_n = 3'h7;
      pins.low_side_drive    = 3'h0;
    end
  end
  // The pull-downs decide the level of any output that the device releases.
  assign pfb_wire   = phase_feedback & phase_feedback_oe;
  assign fault_wire = fault_n & fault_n_oe;
endmodule // bdic_mcu

// [bdic_pkg.sv]
// Types shared by the bridge driver input control.
// Assumes bdic_map.svh for all numeric constants.
package bdic_pkg;
  // Power state of the device.
  typedef enum logic [1:0] {ST_SLEEP, ST_ACTIVE, ST_PWRDN} bdic_state_e;
  // All pin-level inputs, asynchronous to aclk.
  typedef struct packed {
    logic [2:0] high_side_drive_n;  // Active-low high-side drive inputs.
    logic [2:0] low_side_drive;     // Active-high low-side drive inputs.
    logic       stage_enable_clear; // Enable and latched-error clear.
    logic       sleep_request_n;    // Low requests power-down.
    logic       safe_off_n;         // Low forces safe-off.
    logic [2:0] phase_node_cmp;     // Comparator outputs of the phase nodes.
    logic       bootstrap_uv;       // Undervoltage on the bootstrap supply node.
    logic       vcc_uv;             // I/O supply below threshold.
    logic       vcc_ov;             // I/O supply above threshold.
    logic [4:0] pad_short;          // Short detected per digital output pad.
  } bdic_pin_s;
  // Gate drive outputs.
  typedef struct packed {
    logic [2:0] hs_gate; // High-side gate on.
    logic [2:0] ls_gate; // Low-side gate on.
  } bdic_gate_s;
endpackage : bdic_pkg
